//--- logic/edac_host_cfg.svh
// How it works
// - Controller latches the 39-bit word by moving selects from read-flag to latch-input.
// - Corrected word is captured into the output latch on a low-to-high latch enable.
// - A high byte enable frees that byte so the controller drives a modified byte.
// - After altering bytes the controller takes both selects low to regenerate check bits.
`ifndef EDAC_HOST_CFG_SVH
`define EDAC_HOST_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define EDAC_CTRL_ADDR 8'h00
`define EDAC_MEMDATA_ADDR 8'h04
`define EDAC_MEMCHECK_ADDR 8'h08
`define EDAC_MODDATA_ADDR 8'h0C
`define EDAC_BYTEMASK_ADDR 8'h10
`define EDAC_DIAGDATA_ADDR 8'h14
`define EDAC_RESDATA_ADDR 8'h18
`define EDAC_RESCHECK_ADDR 8'h1C
`define EDAC_SYNDROME_ADDR 8'h20
`define EDAC_PASSDATA_ADDR 8'h24

// ****************************************
// fields and reset values
// ****************************************
`define EDAC_OP_LSB 0
`define EDAC_OP_MSB 1
`define EDAC_ST_BUSY 0
`define EDAC_ST_DONE 1
`define EDAC_ST_ERRN 2
`define EDAC_ST_MERRN 3
`define EDAC_ST_CLS_LSB 4
`define EDAC_ST_CLS_MSB 6
`define EDAC_RST_WORD 32'h0000_0000
`define EDAC_RST_CHECK 7'h00
`define EDAC_RST_MASK 4'h0

// ****************************************
// timing
// ****************************************
`define EDAC_CLK_PERIOD_NS 10
`define EDAC_SETTLE_NS 30
`define EDAC_SETTLE_CYC ((`EDAC_SETTLE_NS + `EDAC_CLK_PERIOD_NS - 1) / `EDAC_CLK_PERIOD_NS)

`endif

//--- logic/edac_host_pkg.sv
`default_nettype none
package edac_host_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CHECK,
    OP_RMW,
    OP_DIAG
  } op_t;

  typedef enum logic [2:0] {
    SC_NONE,
    SC_DATA,
    SC_CHECK,
    SC_DOUBLE,
    SC_MULTI
  } synd_class_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FLAG,
    ST_LATCH,
    ST_CAPT,
    ST_GEN,
    ST_DLCHK,
    ST_DVER,
    ST_DPASS,
    ST_DPOUT,
    ST_DCOR
  } state_t;
endpackage
`default_nettype wire

//--- logic/synd_sort.sv
`include "edac_host_cfg.svh"
`default_nettype none
module synd_sort (
  // syndrome and flags
  input wire logic [6:0] syndrome,
  input wire logic errFlagN,
  input wire logic multiFlagN,
  // class
  output edac_host_pkg::synd_class_t cls
);
  import edac_host_pkg::*;

  logic [2:0] lows;

  // ****************************************
  // count syndrome bits that left the all-high idle value
  // ****************************************
  always_comb begin
    lows = 3'd0;
    for (int i = 0; i < 7; i++) begin
      lows = lows + {2'b00, ~syndrome[i]};
    end
  end

  // odd weights of three or more are data bits unless the flags say otherwise
  always_comb begin
    if (lows == 3'd0) begin
      cls = SC_NONE;
    end else if (lows == 3'd1) begin
      cls = SC_CHECK;
    end else if (!lows[0]) begin
      cls = SC_DOUBLE;
    end else if (!errFlagN && multiFlagN) begin
      cls = SC_DATA;
    end else begin
      cls = SC_MULTI;
    end
  end
endmodule
`default_nettype wire

//--- logic/edac_host.sv
`include "edac_host_cfg.svh"
`default_nettype none
module edac_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // software port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // mode, latch and drive-enable controls
  output logic modeSelectHi,
  output logic modeSelectLo,
  output logic outLatchEnableN,
  output logic [3:0] byteDriveEnableN,
  output logic checkPortDriveEnableN,
  // error flags from the device
  input wire logic errFlagN,
  input wire logic multiFaultFlagN,
  // data port
  input wire logic [31:0] dataPortIn,
  output logic [31:0] dataPortOut,
  output logic [31:0] dataPortOe,
  // check port
  input wire logic [6:0] checkPortIn,
  output logic [6:0] checkPortOut,
  output logic [6:0] checkPortOe
);
  import edac_host_pkg::*;

  localparam logic [3:0] SETTLE = 4'(`EDAC_SETTLE_CYC + 1);

  // ****************************************
  // state
  // ****************************************
  state_t state;
  state_t next_state;
  op_t op;
  logic [3:0] waitCnt;
  logic stepEnd;
  logic busy;
  logic done;
  logic [31:0] memData;
  logic [6:0] memCheck;
  logic [31:0] modData;
  logic [3:0] byteMask;
  logic [31:0] diagData;
  logic [31:0] resData;
  logic [6:0] resCheck;
  logic [6:0] syndrome;
  logic [31:0] passData;
  logic capErrN;
  logic capMultiN;
  synd_class_t cls;
  synd_class_t capCls;
  logic ctrlWrite;
  logic [31:0] next_dataOe;
  logic [6:0] next_checkOe;
  logic [31:0] next_dataOut;

  assign ctrlWrite = regWrite && (regAddr == `EDAC_CTRL_ADDR);
  assign busy = (state != ST_IDLE);
  assign stepEnd = busy && (waitCnt == 4'd0);

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      memData <= `EDAC_RST_WORD;
      memCheck <= `EDAC_RST_CHECK;
      modData <= `EDAC_RST_WORD;
      byteMask <= `EDAC_RST_MASK;
      diagData <= `EDAC_RST_WORD;
    end else if (regWrite) begin
      if (regAddr == `EDAC_MEMDATA_ADDR) begin
        memData <= regWdata;
      end else if (regAddr == `EDAC_MEMCHECK_ADDR) begin
        memCheck <= regWdata[6:0];
      end else if (regAddr == `EDAC_MODDATA_ADDR) begin
        modData <= regWdata;
      end else if (regAddr == `EDAC_BYTEMASK_ADDR) begin
        byteMask <= regWdata[3:0];
      end else if (regAddr == `EDAC_DIAGDATA_ADDR) begin
        diagData <= regWdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      if (regAddr == `EDAC_CTRL_ADDR) begin
        regRdata <= {25'h000_0000, 3'(capCls), capMultiN, capErrN, done, busy};
      end else if (regAddr == `EDAC_MEMDATA_ADDR) begin
        regRdata <= memData;
      end else if (regAddr == `EDAC_MEMCHECK_ADDR) begin
        regRdata <= {25'h000_0000, memCheck};
      end else if (regAddr == `EDAC_MODDATA_ADDR) begin
        regRdata <= modData;
      end else if (regAddr == `EDAC_BYTEMASK_ADDR) begin
        regRdata <= {28'h000_0000, byteMask};
      end else if (regAddr == `EDAC_DIAGDATA_ADDR) begin
        regRdata <= diagData;
      end else if (regAddr == `EDAC_RESDATA_ADDR) begin
        regRdata <= resData;
      end else if (regAddr == `EDAC_RESCHECK_ADDR) begin
        regRdata <= {25'h000_0000, resCheck};
      end else if (regAddr == `EDAC_SYNDROME_ADDR) begin
        regRdata <= {25'h000_0000, syndrome};
      end else if (regAddr == `EDAC_PASSDATA_ADDR) begin
        regRdata <= passData;
      end else begin
        regRdata <= 32'h0000_0000;
      end
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ctrlWrite && (op_t'(regWdata[`EDAC_OP_MSB:`EDAC_OP_LSB]) != OP_NONE)) begin
          next_state = ST_FLAG;
        end
      end
      ST_FLAG: begin
        if (stepEnd) begin
          if (op == OP_RMW) begin
            next_state = ST_LATCH;
          end else if (op == OP_DIAG) begin
            next_state = ST_DLCHK;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_LATCH: next_state = stepEnd ? ST_CAPT : ST_LATCH;
      ST_CAPT: next_state = stepEnd ? ST_GEN : ST_CAPT;
      ST_GEN: next_state = stepEnd ? ST_IDLE : ST_GEN;
      ST_DLCHK: next_state = stepEnd ? ST_DVER : ST_DLCHK;
      ST_DVER: next_state = stepEnd ? ST_DPASS : ST_DVER;
      ST_DPASS: next_state = stepEnd ? ST_DPOUT : ST_DPASS;
      ST_DPOUT: next_state = stepEnd ? ST_DCOR : ST_DPOUT;
      ST_DCOR: next_state = stepEnd ? ST_IDLE : ST_DCOR;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      op <= OP_NONE;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_FLAG) begin
        op <= op_t'(regWdata[`EDAC_OP_MSB:`EDAC_OP_LSB]);
      end
    end
  end

  // pins are registered, so each step waits one cycle more than the settle time
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      waitCnt <= 4'd0;
    end else if (next_state != state) begin
      waitCnt <= SETTLE;
    end else if (waitCnt != 4'd0) begin
      waitCnt <= waitCnt - 4'd1;
    end
  end

  // set wins over the clearing write
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done <= 1'b0;
    end else if (busy && next_state == ST_IDLE) begin
      done <= 1'b1;
    end else if (ctrlWrite) begin
      done <= 1'b0;
    end
  end

  // ****************************************
  // device controls
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      modeSelectHi <= 1'b1;
      modeSelectLo <= 1'b0;
      outLatchEnableN <= 1'b0;
      checkPortDriveEnableN <= 1'b1;
      byteDriveEnableN <= 4'hF;
    end else begin
      modeSelectHi <= 1'b1;
      modeSelectLo <= 1'b0;
      outLatchEnableN <= 1'b0;
      checkPortDriveEnableN <= 1'b1;
      byteDriveEnableN <= 4'hF;
      case (state)
        ST_LATCH: begin
          modeSelectLo <= 1'b1;
        end
        ST_CAPT: begin
          modeSelectLo <= 1'b1;
          outLatchEnableN <= 1'b1;
          checkPortDriveEnableN <= 1'b0;
        end
        ST_GEN: begin
          modeSelectHi <= 1'b0;
          outLatchEnableN <= 1'b1;
          checkPortDriveEnableN <= 1'b0;
          byteDriveEnableN <= byteMask;
        end
        ST_DLCHK: begin
          modeSelectHi <= 1'b0;
          modeSelectLo <= 1'b1;
        end
        ST_DVER: begin
          modeSelectHi <= 1'b0;
          modeSelectLo <= 1'b1;
          checkPortDriveEnableN <= 1'b0;
        end
        ST_DPASS: begin
          modeSelectHi <= 1'b0;
          modeSelectLo <= 1'b1;
          outLatchEnableN <= 1'b1;
        end
        ST_DPOUT: begin
          modeSelectLo <= 1'b1;
          outLatchEnableN <= 1'b1;
          byteDriveEnableN <= 4'h0;
          checkPortDriveEnableN <= 1'b0;
        end
        ST_DCOR: begin
          modeSelectLo <= 1'b1;
          byteDriveEnableN <= 4'h0;
          checkPortDriveEnableN <= 1'b0;
        end
        default: begin
          modeSelectHi <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // data and check drive
  // ****************************************
  always_comb begin
    next_dataOe = 32'h0000_0000;
    next_checkOe = 7'h00;
    next_dataOut = memData;
    case (state)
      // word held through the latch step so the input latches never race the release
      ST_FLAG, ST_LATCH: begin
        next_dataOe = 32'hFFFF_FFFF;
        next_checkOe = 7'h7F;
      end
      ST_GEN: begin
        for (int b = 0; b < 4; b++) begin
          next_dataOe[8*b +: 8] = {8{byteMask[b]}};
        end
        next_dataOut = modData;
      end
      ST_DLCHK, ST_DVER, ST_DPASS: begin
        next_dataOe = 32'hFFFF_FFFF;
        next_dataOut = diagData;
      end
      default: begin
        next_dataOe = 32'h0000_0000;
      end
    endcase
  end

  // a wide mask cannot fall into ST_GEN with a stale word
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dataPortOut <= 32'h0000_0000;
      dataPortOe <= 32'h0000_0000;
      checkPortOut <= 7'h00;
      checkPortOe <= 7'h00;
    end else begin
      dataPortOut <= next_dataOut;
      dataPortOe <= next_dataOe;
      checkPortOut <= memCheck;
      checkPortOe <= next_checkOe;
    end
  end

  // ****************************************
  // captures
  // ****************************************
  synd_sort sorter (
    .syndrome(checkPortIn),
    .errFlagN(errFlagN),
    .multiFlagN(multiFaultFlagN),
    .cls(cls)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      capErrN <= 1'b1;
      capMultiN <= 1'b1;
      capCls <= SC_NONE;
    end else if (stepEnd && (state == ST_FLAG || state == ST_CAPT || state == ST_DLCHK
                             || state == ST_DCOR)) begin
      capErrN <= errFlagN;
      capMultiN <= multiFaultFlagN;
      capCls <= (state == ST_FLAG || state == ST_DLCHK) ? SC_NONE : cls;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      syndrome <= 7'h7F;
      resCheck <= `EDAC_RST_CHECK;
    end else if (stepEnd) begin
      if (state == ST_CAPT || state == ST_DCOR) begin
        syndrome <= checkPortIn;
      end else if (state == ST_GEN || state == ST_DVER) begin
        resCheck <= checkPortIn;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      resData <= `EDAC_RST_WORD;
      passData <= `EDAC_RST_WORD;
    end else if (stepEnd) begin
      if (state == ST_GEN || state == ST_DCOR) begin
        resData <= dataPortIn;
      end else if (state == ST_DPOUT) begin
        passData <= dataPortIn;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/edac_host_props.sv
`default_nettype none
module edac_host_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // device pins
  input wire logic modeSelectHi,
  input wire logic modeSelectLo,
  input wire logic outLatchEnableN,
  input wire logic [3:0] byteDriveEnableN,
  input wire logic checkPortDriveEnableN,
  input wire logic [31:0] dataPortOe,
  input wire logic [6:0] checkPortOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] devOn;
  assign devOn = {{8{!byteDriveEnableN[3]}}, {8{!byteDriveEnableN[2]}},
    {8{!byteDriveEnableN[1]}}, {8{!byteDriveEnableN[0]}}};
  // ****************************************
  // pin sequencing
  // ****************************************
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence sLatchOpen;
    modeSelectHi && modeSelectLo && !outLatchEnableN;
  endsequence
  sequence sCaptured;
    modeSelectHi && modeSelectLo && outLatchEnableN;
  endsequence
  AST_BYTE_FREE:
    assert property (|devOn |-> (dataPortOe & devOn) == 32'h0) else $error("byte contention");
  AST_WORD_HELD:
    assert property ($rose(modeSelectLo) && modeSelectHi |-> $past(modeSelectHi)
      && $past(&dataPortOe) && $past(&checkPortOe)) else $error("word not held");
  AST_LATCH_STEP:
    assert property ($rose(modeSelectLo) && modeSelectHi |-> sLatchOpen [*5] ##1 sCaptured)
      else $error("latch step wrong");
  AST_GEN_ORDER:
    assert property ($fell(modeSelectHi) && !modeSelectLo |-> $past(modeSelectLo)
      && $past(outLatchEnableN)) else $error("regenerate too early");
  AST_GEN_PINS:
    assert property (!modeSelectHi && !modeSelectLo |-> !checkPortDriveEnableN
      && checkPortOe == 7'h00 && dataPortOe == ~devOn) else $error("generate pins");
  AST_SYND_FREE:
    assert property (modeSelectHi && modeSelectLo && !checkPortDriveEnableN
      |-> checkPortOe == 7'h00) else $error("check port contention");
  AST_DIAG_PINS:
    assert property (!modeSelectHi && modeSelectLo |-> checkPortOe == 7'h00
      && byteDriveEnableN == 4'hF) else $error("diagnostic pins");
  AST_FLAG_PINS:
    assert property (modeSelectHi && !modeSelectLo && &dataPortOe |-> byteDriveEnableN == 4'hF
      && checkPortDriveEnableN) else $error("flag step pins");
  AST_STEP_HOLD:
    assert property ($changed({modeSelectHi, modeSelectLo}) |=>
      $stable({modeSelectHi, modeSelectLo}) [*3]) else $error("mode step too short");
endmodule
`default_nettype wire

//--- testbench/edac_dev_model.sv
`default_nettype none
module edac_dev_model (
  // controls
  input wire logic modeSelectHi,
  input wire logic modeSelectLo,
  input wire logic outLatchEnableN,
  input wire logic [3:0] byteDriveEnableN,
  input wire logic checkPortDriveEnableN,
  // resolved buses
  input wire logic [31:0] dataBus,
  input wire logic [6:0] checkBus,
  // drive and flags
  output logic [31:0] devData,
  output logic [31:0] devDataOe,
  output logic [6:0] devCheck,
  output logic devCheckOe,
  output logic errFlagN,
  output logic multiFaultFlagN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] inData, outData, fixData;
  logic [6:0] inCheck, syn;
  logic readFlag, fix;
  // ****************************************
  // parity matrix
  // ****************************************
  // columns are weight-3 codes in order, a neutral matrix choice
  function automatic logic [6:0] col(input int i);
    int n;
    n = 0;
    for (int c = 0; c < 128; c++) begin
      if ($countones(c[6:0]) == 3) begin
        if (n == i) return c[6:0];
        n++;
      end
    end
    return 7'h00;
  endfunction
  function automatic logic [6:0] gen(input logic [31:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 32; i++) if (d[i]) c ^= col(i);
    return c;
  endfunction
  assign readFlag = modeSelectHi && !modeSelectLo;
  always_latch begin
    if (!(modeSelectHi && modeSelectLo)) inData <= dataBus;
    if (modeSelectHi && !modeSelectLo) inCheck <= checkBus;
  end
  assign syn = ~(gen(inData) ^ inCheck);
  always_comb begin
    fix = 1'b0;
    fixData = inData;
    for (int i = 0; i < 32; i++) begin
      if (~syn == col(i)) begin
        fix = 1'b1;
        fixData[i] = ~inData[i];
      end
    end
  end
  // diagnostic pass-through skips correction
  always_latch begin
    if (!outLatchEnableN) outData <= modeSelectHi ? fixData : inData;
  end
  assign errFlagN = (!modeSelectHi && !modeSelectLo) || syn == 7'h7F;
  assign multiFaultFlagN = errFlagN || fix || $countones(~syn) == 1;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      devDataOe[8*b +: 8] = {8{!byteDriveEnableN[b] && !readFlag}};
    end
  end
  assign devData = outData;
  assign devCheckOe = !checkPortDriveEnableN && !readFlag;
  assign devCheck = !modeSelectHi ? (modeSelectLo ? inCheck : gen(dataBus)) : syn;
endmodule
`default_nettype wire

//--- testbench/edac_host_tb.sv
`default_nettype none
module edac_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import edac_host_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata, dataPortIn, dataPortOut, dataPortOe, devData, devDataOe;
  logic [31:0] noise = 32'h0000_0000;
  logic [6:0] checkPortIn, checkPortOut, checkPortOe, devCheck;
  logic modeSelectHi, modeSelectLo, outLatchEnableN, checkPortDriveEnableN;
  logic devCheckOe, errFlagN, multiFaultFlagN;
  logic [3:0] byteDriveEnableN;
  int fails = 0;
  int comparisons = 0;
  always #5 core_clk = ~core_clk;
  // released lines carry a twisted ring that flips one line each cycle, so a stale value is unlikely to pass
  always @(posedge core_clk) noise <= {noise[30:0], ~noise[31]};
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      dataPortIn[i] = dataPortOe[i] ? (devDataOe[i] ? 1'bx : dataPortOut[i])
        : (devDataOe[i] ? devData[i] : noise[i]);
    end
    for (int i = 0; i < 7; i++) begin
      checkPortIn[i] = checkPortOe[i] ? (devCheckOe ? 1'bx : checkPortOut[i])
        : (devCheckOe ? devCheck[i] : noise[i]);
    end
  end
  edac_host i_dut (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .modeSelectHi(modeSelectHi), .modeSelectLo(modeSelectLo),
    .outLatchEnableN(outLatchEnableN), .byteDriveEnableN(byteDriveEnableN),
    .checkPortDriveEnableN(checkPortDriveEnableN), .errFlagN(errFlagN),
    .multiFaultFlagN(multiFaultFlagN), .dataPortIn(dataPortIn), .dataPortOut(dataPortOut),
    .dataPortOe(dataPortOe), .checkPortIn(checkPortIn), .checkPortOut(checkPortOut),
    .checkPortOe(checkPortOe)
  );
  edac_dev_model i_dev (
    .modeSelectHi(modeSelectHi), .modeSelectLo(modeSelectLo),
    .outLatchEnableN(outLatchEnableN), .byteDriveEnableN(byteDriveEnableN),
    .checkPortDriveEnableN(checkPortDriveEnableN), .dataBus(dataPortIn),
    .checkBus(checkPortIn), .devData(devData), .devDataOe(devDataOe), .devCheck(devCheck),
    .devCheckOe(devCheckOe), .errFlagN(errFlagN), .multiFaultFlagN(multiFaultFlagN)
  );
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge core_clk);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask
  task automatic run(input op_t op, output logic [31:0] s);
    wr(8'h00, {30'h0, op});
    s = 32'h0;
    for (int n = 0; n < 40 && s[1] !== 1'b1; n++) rd(8'h00, s);
  endtask
  task automatic stop_test();
    $display("TB: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // whole run is well under 2000 cycles
  initial begin
    #100us;
    fails++;
    stop_test();
  end
  initial begin
    logic [31:0] d, bad, m, mix, s;
    logic [3:0] mk;
    int p;
    void'($urandom(36425));
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rc("ctrl", 8'h00, 32'h0000_000C);
    rc("syndrome", 8'h20, 32'h7F);
    d = $urandom;
    wr(8'h04, d);
    wr(8'h30, 32'hFFFF_FFFF);
    rc("memData", 8'h04, d);
    rc("unmapped", 8'h30, 32'h0);
    $display("TB: test regs done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      p = $urandom_range(30);
      bad = d ^ ((k == 1) ? 32'h1 << p : (k == 3) ? 32'h3 << p : 32'h0);
      wr(8'h04, bad);
      wr(8'h08, {25'h0, (k == 2) ? i_dev.gen(d) ^ 7'h40 : i_dev.gen(d)});
      run(OP_CHECK, s);
      chk("flags", {28'h0, k != 3, k == 0, 2'h2}, s & 32'hF);
    end
    $display("TB: test check done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      m = $urandom;
      mk = (k == 1) ? 4'h0 : (k == 2) ? 4'hF : 4'($urandom);
      p = (k == 1) ? 0 : (k == 2) ? 31 : int'($urandom_range(30, 1));
      bad = (k == 0) ? d : d ^ (32'h1 << p);
      mix = d;
      for (int b = 0; b < 4; b++) if (mk[b]) mix[8*b +: 8] = m[8*b +: 8];
      wr(8'h04, bad);
      wr(8'h08, {25'h0, i_dev.gen(d)});
      wr(8'h0C, m);
      wr(8'h10, {28'h0, mk});
      run(OP_RMW, s);
      chk("rmw status", (k == 0) ? {25'h0, SC_NONE, 4'hE} : {25'h0, SC_DATA, 4'hA}, s);
      rc("resData", 8'h18, mix);
      rc("resCheck", 8'h1C, {25'h0, i_dev.gen(mix)});
      rc("syndrome", 8'h20, {25'h0, ~i_dev.gen(bad ^ d)});
    end
    $display("TB: test rmw done");
    for (int k = 1; k < 3; k++) begin
      d = $urandom;
      p = $urandom_range(30);
      bad = d ^ ((k == 1 ? 32'h1 : 32'h3) << p);
      wr(8'h04, d);
      wr(8'h08, {25'h0, i_dev.gen(d)});
      wr(8'h14, bad);
      run(OP_DIAG, s);
      chk("diag status", (k == 1) ? {25'h0, SC_DATA, 4'hA} : {25'h0, SC_DOUBLE, 4'h2}, s);
      rc("resCheck", 8'h1C, {25'h0, i_dev.gen(d)});
      rc("passData", 8'h24, bad);
      rc("resData", 8'h18, (k == 1) ? d : bad);
      rc("syndrome", 8'h20, {25'h0, ~i_dev.gen(bad ^ d)});
    end
    $display("TB: test diag done");
    stop_test();
  end
endmodule
bind edac_host edac_host_props i_props (
  .core_clk(core_clk), .resetn(resetn), .modeSelectHi(modeSelectHi),
  .modeSelectLo(modeSelectLo), .outLatchEnableN(outLatchEnableN),
  .byteDriveEnableN(byteDriveEnableN), .checkPortDriveEnableN(checkPortDriveEnableN),
  .dataPortOe(dataPortOe), .checkPortOe(checkPortOe)
);
`default_nettype wire
